// *** rtl/uart_interrupt_enable_status.sv ***
/*
  Interrupt mask, priority encoder, source-code and line-status reporting
  for a fifo UART, reached over APB.
  Assumes the UART core supplies the event struct on pclk, except cts_n
  which is a pin and is synchronised here.
*/
// Register access over APB and the register offsets are this design's own decisions.
module uart_interrupt_enable_status (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // uart core side
  input  wire uart_irq_pkg::uart_ev_t  ev,
  output uart_irq_pkg::irq_out_t       out
);
  typedef enum logic [7:0] {
    SRC_NONE  = 8'h01,
    SRC_LINE  = 8'h02,
    SRC_TOUT  = 8'h04,
    SRC_RXD   = 8'h08,
    SRC_TXR   = 8'h10,
    SRC_MODEM = 8'h20,
    SRC_CHAR  = 8'h40,
    SRC_FLOW  = 8'h80
  } src_t;

  logic [7:0]  mask_q, mask_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic        line_q, line_d;
  logic        txr_q, txr_d;
  logic        tout_q, tout_d;
  logic        char_q, char_d;
  logic        flow_q, flow_d;
  logic        wake_q, wake_d;
  logic        ovr_q, ovr_d;
  logic        txe_q, txe_d;
  logic        rts_q, rts_d;
  logic        cts_s1_q, cts_s2_q, cts_s3_q;
  logic [5:0]  tcnt_q, tcnt_d;
  logic [31:0] prdata_q, prdata_d;
  src_t        src;
  logic [7:0]  line_condition_reg;

  wire acc   = psel && penable;
  wire wr    = acc && pwrite;
  wire rd    = acc && !pwrite;
  wire enh   = ctrl_q[uart_irq_pkg::CTRL_ENH_EN];
  wire fifo  = ctrl_q[uart_irq_pkg::CTRL_FIFO_EN];
  wire rd_src  = rd && paddr == uart_irq_pkg::OFF_SOURCE;
  wire rd_line = rd && paddr == uart_irq_pkg::OFF_LINE;
  wire mapped  = paddr == uart_irq_pkg::OFF_MASK || paddr == uart_irq_pkg::OFF_SOURCE
              || paddr == uart_irq_pkg::OFF_LINE || paddr == uart_irq_pkg::OFF_CTRL
              || paddr == uart_irq_pkg::OFF_TOUT;

  // pending sources: core levels and the sticky flags held in this block
  wire rxd_pend   = mask_q[0] && (fifo ? ev.rx_at_trig : !ev.rx_empty);
  wire err_now    = ctrl_q[uart_irq_pkg::CTRL_ERR_AT_ENTRY] ? 1'b0 : |ev.head_err;
  wire line_pend  = mask_q[2] && (line_q || err_now);
  wire modem_pend = mask_q[3] && |ev.modem_delta;
  wire tout_pend  = mask_q[0] && tout_q;
  wire txr_pend   = mask_q[1] && txr_q;
  wire char_pend  = enh && mask_q[5] && char_q;
  wire flow_pend  = enh && (mask_q[6] | mask_q[7]) && flow_q;

  // fixed priority; lower sources stay pending until their own clear, except tx ready and char match, which any source read clears
  always_comb begin
    if (line_pend)       src = SRC_LINE;
    else if (tout_pend)  src = SRC_TOUT;
    else if (rxd_pend)   src = SRC_RXD;
    else if (txr_pend)   src = SRC_TXR;
    else if (modem_pend) src = SRC_MODEM;
    else if (char_pend)  src = SRC_CHAR;
    else if (flow_pend)  src = SRC_FLOW;
    else                 src = SRC_NONE;
  end

  function automatic logic [5:0] src_code(input src_t s);
    case (s)
      SRC_LINE:  src_code = uart_irq_pkg::CODE_LINE;
      SRC_TOUT:  src_code = uart_irq_pkg::CODE_TOUT;
      SRC_RXD:   src_code = uart_irq_pkg::CODE_RXD;
      SRC_TXR:   src_code = uart_irq_pkg::CODE_TXR;
      SRC_MODEM: src_code = uart_irq_pkg::CODE_MODEM;
      SRC_CHAR:  src_code = uart_irq_pkg::CODE_CHAR;
      SRC_FLOW:  src_code = uart_irq_pkg::CODE_FLOW;
      default:   src_code = uart_irq_pkg::CODE_NONE;
    endcase
  endfunction

  // line status view; polled mode needs no enables at all
  always_comb begin
    line_condition_reg[0]   = !ev.rx_empty;
    line_condition_reg[1]   = ovr_q;
    line_condition_reg[4:2] = ev.head_err;
    line_condition_reg[5]   = ev.tx_empty;
    line_condition_reg[6]   = ev.tx_all_empty;
    line_condition_reg[7]   = ev.any_fifo_err;
  end

  always_comb begin
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    if (wr && paddr == uart_irq_pkg::OFF_MASK) begin
      mask_d[3:0] = pwdata[3:0];
      if (enh) begin
        mask_d[7:4] = pwdata[7:4];
      end
    end
    if (wr && paddr == uart_irq_pkg::OFF_CTRL) begin
      ctrl_d = pwdata[7:0];
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_comb begin
    ovr_d  = (ovr_q && !rd_line) || ev.overrun;
    line_d = (line_q && !rd_line) || ev.overrun
          || (ctrl_q[uart_irq_pkg::CTRL_ERR_AT_ENTRY] && ev.rx_push && |ev.push_err);
    txe_d  = ev.tx_empty;
    txr_d  = txr_q;
    if (rd_src || ev.tx_write) begin
      txr_d = 1'b0;
    end
    if ((fifo ? ev.tx_below_trig : (ev.tx_empty && !txe_q))
        || (wr && paddr == uart_irq_pkg::OFF_MASK && pwdata[1] && !mask_q[1] && ev.tx_empty)) begin
      txr_d = 1'b1;
    end
    char_d = char_q;
    if (rd_src || ev.rx_push) begin
      char_d = 1'b0;
    end
    if (ev.char_match) begin
      char_d = 1'b1;
    end
    rts_d  = ev.rts_n;
    flow_d = flow_q;
    if (ev.modem_read) begin
      flow_d = 1'b0;
    end
    if ((mask_q[6] && ctrl_q[uart_irq_pkg::CTRL_AUTO_RTS] && ev.rts_n && !rts_q)
        || (mask_q[7] && ctrl_q[uart_irq_pkg::CTRL_AUTO_CTS] && cts_s2_q && !cts_s3_q)) begin
      flow_d = 1'b1;
    end
    wake_d = (wake_q && !rd_src) || ev.woke;
  end

  // receive timeout counts bit times while data idles in the fifo
  always_comb begin
    tcnt_d = tcnt_q;
    tout_d = tout_q;
    if (ev.rx_read) begin
      tout_d = 1'b0;
    end
    if (ev.rx_empty || ev.rx_push || ev.rx_read) begin
      tcnt_d = '0;
    end else if (ev.bit_tick) begin
      if (tcnt_q == 6'(uart_irq_pkg::TOUT_BITS - 1)) begin
        tout_d = 1'b1;
        tcnt_d = '0;
      end else begin
        tcnt_d = tcnt_q + 6'h01;
      end
    end
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        uart_irq_pkg::OFF_MASK:   prdata_d[7:0] = mask_q;
        uart_irq_pkg::OFF_SOURCE: prdata_d[7:0] = {{2{fifo}}, src_code(src)};
        uart_irq_pkg::OFF_LINE:   prdata_d[7:0] = line_condition_reg;
        uart_irq_pkg::OFF_CTRL:   prdata_d[7:0] = ctrl_q;
        uart_irq_pkg::OFF_TOUT:   prdata_d[7:0] = {1'b0, wake_q, tcnt_q};
        default:                  prdata_d = 32'h0000_0000;
      endcase
    end else if (acc) begin
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q   <= uart_irq_pkg::MASK_RESET;
      ctrl_q   <= uart_irq_pkg::CTRL_RESET;
      line_q   <= 1'b0;
      ovr_q    <= 1'b0;
      txr_q    <= 1'b0;
      txe_q    <= 1'b0;
      tout_q   <= 1'b0;
      tcnt_q   <= 6'h00;
      char_q   <= 1'b0;
      flow_q   <= 1'b0;
      rts_q    <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      cts_s3_q <= 1'b1;
      wake_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      mask_q   <= mask_d;
      ctrl_q   <= ctrl_d;
      line_q   <= line_d;
      ovr_q    <= ovr_d;
      txr_q    <= txr_d;
      txe_q    <= txe_d;
      tout_q   <= tout_d;
      tcnt_q   <= tcnt_d;
      char_q   <= char_d;
      flow_q   <= flow_d;
      rts_q    <= rts_d;
      cts_s1_q <= ev.cts_n;
      cts_s2_q <= cts_s1_q;
      cts_s3_q <= cts_s2_q;
      wake_q   <= wake_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = 1'b1;
  assign pslverr         = acc && !mapped;
  assign out.irq         = src != SRC_NONE;
  assign out.sleep_en    = mask_q[4];
  assign out.line_status = line_condition_reg;
endmodule

// *** pkg/uart_irq_pkg.sv ***
/*
  Package for the UART interrupt enable/status block: APB offsets, field
  positions, reset values, source codes and carrier structs.
  Assumes a 32-bit APB master and a UART core that supplies event levels.
*/
// Functional notes
// - rx data interrupt follows fifo trigger level
// - data-ready flag set on push, clear empty
// - enables 0-3 clear gives polled mode
// - line status bits 0..7 layout as documented
// - rx enable: char present or trigger reached
// - tx ready on empty/below trigger, also at enable
// - overrun immediate; errors at head or entry
// - modem change bits 0-3 interrupt when enabled
// - upper enable bits writable only with enhanced enable
// - rts low-to-high interrupts under auto rts
// - cts low-to-high interrupts under auto cts
// - status read shows highest, others stay queued; any status read here also clears tx ready and char match
// - timeout after 4 chars plus 12 bits
// - tx ready cleared by status read or write
// - xon/xoff/special interrupt and its clearing
// - line read clears line; modem read clears modem, flow
// - rx data interrupt cleared only by level crossing
// - wake-up flag raises no irq, cleared by status read; source reads 01
// - six-bit source codes by priority
// - bit 0 low while pending, reset high
// - bit 4 xon/xoff/special only with enhanced enable
// - bit 5 cts/rts change only with enhanced enable
// - bits 7:6 follow fifo enable
package uart_irq_pkg;
  localparam logic [11:0] OFF_MASK   = 12'h000;
  localparam logic [11:0] OFF_SOURCE = 12'h004;
  localparam logic [11:0] OFF_LINE   = 12'h008;
  localparam logic [11:0] OFF_CTRL   = 12'h00C;
  localparam logic [11:0] OFF_TOUT   = 12'h010;

  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] CODE_LINE  = 6'h06;
  localparam logic [5:0] CODE_TOUT  = 6'h0C;
  localparam logic [5:0] CODE_RXD   = 6'h04;
  localparam logic [5:0] CODE_TXR   = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_CHAR  = 6'h10;
  localparam logic [5:0] CODE_FLOW  = 6'h20;
  localparam logic [5:0] CODE_NONE  = 6'h01;

  // control register fields (written by software)
  localparam int CTRL_FIFO_EN  = 0;
  localparam int CTRL_ENH_EN   = 1;
  localparam int CTRL_AUTO_RTS = 2;
  localparam int CTRL_AUTO_CTS = 3;
  localparam int CTRL_ERR_AT_ENTRY = 4;

  // timeout: 4 chars of 10 bits plus 12 bits, in bit times
  localparam int TOUT_CHAR_BITS = 10;
  localparam int TOUT_BITS      = 4 * TOUT_CHAR_BITS + 12;

  typedef struct packed {
    logic       rx_push;      // char moved from shifter into fifo
    logic       rx_empty;
    logic       rx_at_trig;   // level at or above trigger
    logic       rx_read;      // host read of receive holding reg
    logic       tx_empty;     // holding reg / fifo empty
    logic       tx_below_trig;
    logic       tx_all_empty; // fifo and shifter empty
    logic       tx_write;     // host write of transmit holding reg
    logic       overrun;
    logic [2:0] head_err;     // parity, framing, break at read head
    logic [2:0] push_err;     // same, of char being pushed
    logic       any_fifo_err;
    logic [3:0] modem_delta;
    logic       modem_read;
    logic       char_match;   // xon, xoff or special detected
    logic       rts_n;
    logic       cts_n;        // raw pin, synchronised inside
    logic       woke;         // pulse on leaving sleep
    logic       bit_tick;     // one pulse per bit time
  } uart_ev_t;

  typedef struct packed {
    logic       irq;
    logic       sleep_en;
    logic [7:0] line_status;
  } irq_out_t;
endpackage

// *** testbench/uart_interrupt_enable_status_properties.sv ***
/*
  Checker for the interrupt block, watching its ports only.
  Assumes zero-wait APB and shadows mask/ctrl from observed writes.
*/
module uart_irq_checker (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // uart core side
  input wire uart_irq_pkg::uart_ev_t ev,
  input wire uart_irq_pkg::irq_out_t out
);
  logic [7:0] mask_q, mask_d, ctrl_q, ctrl_d;
  logic       wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_comb begin
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    if (wr && paddr == uart_irq_pkg::OFF_MASK) begin
      mask_d = ctrl_q[1] ? pwdata[7:0] : {mask_q[7:4], pwdata[3:0]};
    end
    if (wr && paddr == uart_irq_pkg::OFF_CTRL) begin
      ctrl_d = pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= uart_irq_pkg::MASK_RESET;
      ctrl_q <= uart_irq_pkg::CTRL_RESET;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_view; out.line_status[7:2] == {ev.any_fifo_err, ev.tx_all_empty, ev.tx_empty, ev.head_err}; endproperty
  a_view: assert property (p_view) else $error("line status view wrong");
  property p_ovr; ev.overrun |=> out.line_status[1]; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_lclr; rd && paddr == uart_irq_pkg::OFF_LINE && !ev.overrun |=> !out.line_status[1]; endproperty
  a_lclr: assert property (p_lclr) else $error("line read left overrun");
  property p_rdy; ev.rx_push |=> out.line_status[0]; endproperty
  a_rdy: assert property (p_rdy) else $error("data ready not set");
  property p_bit0; rd && paddr == uart_irq_pkg::OFF_SOURCE |-> prdata[0] == !$past(out.irq); endproperty
  a_bit0: assert property (p_bit0) else $error("code bit 0 disagrees with irq");
  property p_poll; mask_q == 8'h00 |-> !out.irq; endproperty
  a_poll: assert property (p_poll) else $error("irq while all masked");
  property p_mdm; mask_q[3] && ev.modem_delta != 4'h0 |-> out.irq; endproperty
  a_mdm: assert property (p_mdm) else $error("modem change not raised");
  property p_rxt; mask_q[0] && ctrl_q[0] && ev.rx_at_trig |-> out.irq; endproperty
  a_rxt: assert property (p_rxt) else $error("trigger level not raised");
  property p_fifo; rd && paddr == uart_irq_pkg::OFF_SOURCE |-> prdata[7:6] == {2{$past(ctrl_q[0])}}; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo bits wrong");
endmodule
bind uart_interrupt_enable_status uart_irq_checker uart_irq_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ev(ev), .out(out));

// *** testbench/apb_host_model.sv ***
/*
  Host processor model: an APB master driven through its xfer task.
  Assumes the caller enters xfer just after a rising edge of pclk.
*/
module apb_host_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [11:0]      paddr = 12'h000,
  output logic [31:0]      pwdata = 32'h0000_0000,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung = 1'b0;
  // slave error, taken at the same edge as the read data
  logic err = 1'b0;
  // host polls any register it likes, masked or not
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    if (n >= 32) hung = 1'b1;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** testbench/uart_interrupt_enable_status_bench.sv ***
/*
  Self-checking bench for the interrupt block: host model on APB, bench
  drives the UART core events. Assumes the source codes of the package.
*/
module uart_interrupt_enable_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, r;
  uart_irq_pkg::uart_ev_t ev;
  uart_irq_pkg::irq_out_t out;
  int                     fail_count = 0;
  int                     checks = 0;
  initial forever #4 pclk = ~pclk;
  apb_host_model apb_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  uart_interrupt_enable_status uart_interrupt_enable_status_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ev(ev), .out(out));
  function automatic logic [31:0] code(input logic f, input logic [5:0] c);
    return {24'h00_0000, f, f, c};
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_host_model_inst.xfer(w, a, d, r);
    if (apb_host_model_inst.hung) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(r, e);
  endtask
  task automatic src(input logic [31:0] e);
    rd(uart_irq_pkg::OFF_SOURCE, e);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    ev = '0;
    ev.rx_empty = 1'b1;
    void'($urandom(32'hB318));
    tk(5);
    presetn <= 1'b1;
    rd(uart_irq_pkg::OFF_MASK, 32'h0000_0000);
    src(code(1'b0, uart_irq_pkg::CODE_NONE));
    ev.head_err <= 3'($urandom);
    bus(1'b1, uart_irq_pkg::OFF_MASK, 32'h0000_00FF);
    rd(uart_irq_pkg::OFF_MASK, 32'h0000_000F);
    ev.head_err <= 3'h0;
    bus(1'b1, 12'h020, 32'h0000_00FF);
    cmp({31'h0, apb_host_model_inst.err}, 32'h0000_0001);
    rd(12'h020, 32'h0000_0000);
    bus(1'b1, uart_irq_pkg::OFF_CTRL, 32'h0000_0003);
    bus(1'b1, uart_irq_pkg::OFF_MASK, 32'h0000_001D);
    rd(uart_irq_pkg::OFF_MASK, 32'h0000_001D);
    cmp({31'h0, out.sleep_en}, 32'h0000_0001);
    ev.modem_delta <= 4'($urandom_range(1, 15));
    ev.rx_at_trig <= 1'b1;
    ev.rx_empty <= 1'b0;
    ev.overrun <= 1'b1;
    tk(1);
    ev.overrun <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_LINE));
    rd(uart_irq_pkg::OFF_LINE, 32'h0000_0003);
    src(code(1'b1, uart_irq_pkg::CODE_RXD));
    ev.rx_at_trig <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_MODEM));
    cmp({31'h0, out.irq}, 32'h0000_0001);
    ev.modem_delta <= 4'h0;
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    ev.tx_empty <= 1'b1;
    bus(1'b1, uart_irq_pkg::OFF_MASK, 32'h0000_0002);
    ev.tx_empty <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_TXR));
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    // fifo mode: the below-trigger event sets tx ready, a holding write clears it
    ev.tx_below_trig <= 1'b1;
    tk(1);
    ev.tx_below_trig <= 1'b0;
    ev.tx_write <= 1'b1;
    tk(1);
    cmp({31'h0, out.irq}, 32'h0000_0001);
    ev.tx_write <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    bus(1'b1, uart_irq_pkg::OFF_MASK, 32'h0000_0020);
    bus(1'b1, uart_irq_pkg::OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      ev.char_match <= 1'b1;
      tk(1);
      ev.char_match <= 1'b0;
      src(i ? code(1'b1, uart_irq_pkg::CODE_CHAR) : code(1'b1, uart_irq_pkg::CODE_NONE));
      src(code(1'b1, uart_irq_pkg::CODE_NONE));
      bus(1'b1, uart_irq_pkg::OFF_CTRL, 32'h0000_0003);
    end
    // the next received character also drops a pending match
    ev.char_match <= 1'b1;
    tk(1);
    ev.char_match <= 1'b0;
    ev.rx_push <= 1'b1;
    tk(1);
    ev.rx_push <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    // rts then cts, each under its own auto flow bit
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, uart_irq_pkg::OFF_CTRL, i ? 32'h0000_000B : 32'h0000_0007);
      bus(1'b1, uart_irq_pkg::OFF_MASK, i ? 32'h0000_0080 : 32'h0000_0040);
      if (i) ev.cts_n <= 1'b1;
      else ev.rts_n <= 1'b1;
      tk(4);
      src(code(1'b1, uart_irq_pkg::CODE_FLOW));
      ev.modem_read <= 1'b1;
      tk(1);
      ev.modem_read <= 1'b0;
      src(code(1'b1, uart_irq_pkg::CODE_NONE));
    end
    bus(1'b1, uart_irq_pkg::OFF_CTRL, 32'h0000_0001);
    bus(1'b1, uart_irq_pkg::OFF_MASK, 32'h0000_0001);
    ev.rx_push <= 1'b1;
    tk(1);
    ev.rx_push <= 1'b0;
    for (int i = 0; i < uart_irq_pkg::TOUT_BITS; i++) begin
      if (i == uart_irq_pkg::TOUT_BITS - 1) src(code(1'b1, uart_irq_pkg::CODE_NONE));
      ev.bit_tick <= 1'b1;
      tk(1);
      ev.bit_tick <= 1'b0;
      tk(1);
    end
    src(code(1'b1, uart_irq_pkg::CODE_TOUT));
    // the read drains the fifo, so it goes empty too
    ev.rx_read <= 1'b1;
    ev.rx_empty <= 1'b1;
    tk(1);
    ev.rx_read <= 1'b0;
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    ev.woke <= 1'b1;
    tk(1);
    ev.woke <= 1'b0;
    rd(uart_irq_pkg::OFF_TOUT, 32'h0000_0040);
    src(code(1'b1, uart_irq_pkg::CODE_NONE));
    rd(uart_irq_pkg::OFF_TOUT, 32'h0000_0000);
    bus(1'b1, uart_irq_pkg::OFF_CTRL, 32'h0000_0000);
    src(code(1'b0, uart_irq_pkg::CODE_NONE));
    // non-fifo mode: one character in the holding register is enough
    ev.rx_empty <= 1'b0;
    src(code(1'b0, uart_irq_pkg::CODE_RXD));
    report_and_stop();
  end
endmodule
